//--- src/serial_rom_config_loader.sv
// Board setup loader: host registers, strap handling and ROM operation sequencing
//
// Overview of operation
// RULE_01: After reset, fetch station address, base and configuration from the ROM.
// RULE_02: ROM is 64 words of 16 bits, addressed by word, whole words only.
// RULE_03: Configuration word at slot strap times four, base word at the next.
// RULE_04: Station address lives in words 20h to 22h, low byte first.
// RULE_05: Slot strap 7 loads only the station address, keeps other defaults.
// RULE_06: Straps all high force the fixed default base regardless of ROM.
// RULE_07: Normal reload refreshes configuration, base and station address.
// RULE_08: Normal store writes configuration and base to the strap slot.
// RULE_09: Three low control bits are never stored to or loaded from ROM.
// RULE_10: General reload copies the pointed ROM word into the general register.
// RULE_11: General store writes the general register to the pointed ROM word.
// RULE_12: Software sets reload or store; hardware clears it when finished.
// RULE_13: During any access, control reads show reload and store both set.
// RULE_14: Other register reads and writes are blocked while an access runs.
// RULE_15: ROM absent strap low: never touch the ROM, keep reset defaults.
// RULE_16: Drive select, clock and data with standard three-wire frames.
// RULE_17: One access at a time; the reset load goes first.
//
// Local design decisions: strobed register access and the address map.
`include "rom_loader_params.svh"
module serial_rom_config_loader #(
    parameter int POLL_MAX = `READY_POLL_MAX
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // Host register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [15:0]      reg_rdata,
    // Straps
    input  wire logic [2:0]  board_slot_straps,
    input  wire logic        rom_present_strap,
    // Serial ROM pins
    output logic             rom_cs,
    output logic             rom_sck,
    output logic             rom_di,
    input  wire logic        rom_do,
    // Loaded setup for the rest of the device
    output logic [15:0]      config_word,
    output logic [15:0]      base_word,
    output logic [47:0]      station_addr
);
    initial begin
        if (POLL_MAX < 1) $error("POLL_MAX must be at least one");
    end
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and strap capture
    logic [1:0] do_sync_q;
    logic [2:0] slot_m_q, slot_q;
    logic       pres_m_q, pres_q;
    logic       strap_ok_q;
    // Two flops for every pin input before any logic reads it
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            do_sync_q <= 2'b00;
            slot_m_q <= 3'h0;
            slot_q <= 3'h0;
            pres_m_q <= 1'b0;
            pres_q <= 1'b0;
        end else begin
            do_sync_q <= {do_sync_q[0], rom_do};
            slot_m_q <= board_slot_straps;
            slot_q <= slot_m_q;
            pres_m_q <= rom_present_strap;
            pres_q <= pres_m_q;
        end
    end
    // Straps settle through the synchroniser before the reset load may start
    logic [1:0] settle_q;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            settle_q <= 2'b00;
        end else if (settle_q != 2'b11) begin
            settle_q <= settle_q + 2'b01;
        end
    end
    assign strap_ok_q = settle_q == 2'b11;
    ////////////////////////////////////////////////////////////////////////////
    // Serial engine and divider
    logic                     eng_start, eng_busy, eng_done, eng_run, tick;
    logic [15:0]              eng_rdata;
    rom_loader_pkg::rom_cmd_s eng_cmd;
    sclk_divider #(.HALF_CYC(`SCLK_HALF_CYC)) i_sclk_divider (
        .clk_sys (clk_sys),
        .reset   (reset),
        .run     (eng_run),
        .tick    (tick)
    );
    rom_serial_engine #(.POLL_MAX(POLL_MAX)) i_rom_serial_engine (
        .clk_sys (clk_sys),
        .reset   (reset),
        .start   (eng_start),
        .cmd     (eng_cmd),
        .busy    (eng_busy),
        .done    (eng_done),
        .rdata   (eng_rdata),
        .tick    (tick),
        .run     (eng_run),
        .rom_cs  (rom_cs),
        .rom_sck (rom_sck),
        .rom_di  (rom_di),
        .rom_do  (do_sync_q[1])
    );
    ////////////////////////////////////////////////////////////////////////////
    // Operation sequencer
    typedef enum logic [2:0] {O_BOOT = 3'b000, O_IDLE = 3'b001, O_PLAN = 3'b011,
                              O_ISSUE = 3'b010, O_WAIT = 3'b110} op_e;
    op_e        op_q;
    logic       is_store_q, is_gp_q;
    logic [2:0] step_q, last_q;
    logic [15:0] cfg_q, base_q, gp_q, ptr_q;
    logic [15:0] ia_q [3];
    logic       sel_q, reload_q, store_q;
    logic       blocked;
    logic [5:0] slot_base;
    assign slot_base = {1'b0, slot_q, 2'b00}; // [RULE_03]
    assign blocked = op_q != O_IDLE; // [RULE_14]
    // Step list: 0 cfg, 1 base, 2-4 address words; store adds write-enable frames
    function automatic rom_loader_pkg::rom_cmd_s step_cmd(input logic [2:0] s, input logic st,
                                                          input logic gp, input logic [5:0] sb,
                                                          input logic [15:0] p, input logic [15:0] c,
                                                          input logic [15:0] b, input logic [15:0] g);
        rom_loader_pkg::rom_cmd_s r;
        r = '0;
        if (st && !s[0]) begin
            r.wren = 1'b1; // [RULE_16]
        end else if (gp) begin
            r.write = st;
            r.addr = p[5:0]; // [RULE_10] [RULE_11]
            r.data = g;
        end else if (st) begin
            r.write = 1'b1;
            r.addr = s[1] ? sb + 6'h01 : sb; // [RULE_08]
            r.data = s[1] ? b : c;
        end else begin
            r.addr = (s >= 3'd2) ? 6'(`ROM_ADDR_AREA + 6'(s - 3'd2)) : sb + 6'(s); // [RULE_02] [RULE_04]
        end
        return r;
    endfunction : step_cmd
    assign eng_cmd = step_cmd(step_q, is_store_q, is_gp_q, slot_base, ptr_q, cfg_q, base_q, gp_q);
    assign eng_start = op_q == O_ISSUE;
    // One access in flight; reset load before any software request
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            op_q <= O_BOOT;
            is_store_q <= 1'b0;
            is_gp_q <= 1'b0;
            step_q <= 3'h0;
            last_q <= 3'h0;
        end else begin
            unique case (op_q)
                O_BOOT: if (strap_ok_q) begin
                    is_store_q <= 1'b0;
                    is_gp_q <= 1'b0;
                    step_q <= (slot_q == `SLOT_DEFAULT) ? 3'd2 : 3'd0; // [RULE_05]
                    last_q <= 3'd4;
                    op_q <= pres_q ? O_ISSUE : O_IDLE; // [RULE_01] [RULE_15] [RULE_17]
                end
                O_IDLE: if (reload_q || store_q) begin
                    op_q <= pres_q ? O_PLAN : O_WAIT; // [RULE_15]
                end
                O_PLAN: begin
                    is_store_q <= store_q && !reload_q; // [RULE_17]
                    is_gp_q <= sel_q;
                    if (store_q && !reload_q) begin
                        step_q <= 3'd0;
                        last_q <= sel_q ? 3'd1 : 3'd3;
                    end else begin
                        step_q <= (sel_q || slot_q != `SLOT_DEFAULT) ? 3'd0 : 3'd2;
                        last_q <= sel_q ? 3'd0 : 3'd4; // [RULE_07]
                    end
                    op_q <= O_ISSUE;
                end
                O_ISSUE: op_q <= O_WAIT;
                O_WAIT: if (!pres_q || eng_done) begin
                    if (pres_q && step_q != last_q) begin
                        step_q <= step_q + 3'h1;
                        op_q <= O_ISSUE;
                    end else begin
                        op_q <= O_IDLE;
                    end
                end
                default: op_q <= O_IDLE;
            endcase
        end
    end
    logic load_done;
    assign load_done = op_q == O_WAIT && eng_done && !is_store_q;
    ////////////////////////////////////////////////////////////////////////////
    // Host register writes and ROM loads
    logic wr_ok;
    assign wr_ok = reg_wr && !blocked;
    // Control bits: set by software; reload and store cleared by hardware at finish
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sel_q <= 1'b0;
            reload_q <= 1'b0;
            store_q <= 1'b0;
        end else if (op_q == O_WAIT && (!pres_q || (eng_done && step_q == last_q))) begin
            if (is_store_q || !pres_q) begin
                store_q <= 1'b0; // [RULE_12]
            end
            if (!is_store_q || !pres_q) begin
                reload_q <= 1'b0; // [RULE_12]
            end
        end else if (wr_ok && reg_addr == `REG_CONTROL) begin
            sel_q <= reg_wdata[`CTL_SELECT];
            reload_q <= reg_wdata[`CTL_RELOAD];
            store_q <= reg_wdata[`CTL_STORE];
        end
    end
    // Setup words: host writes when idle, ROM loads by step; control bits never come from ROM
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cfg_q <= `CONFIG_RESET;
            base_q <= `BASE_RESET;
            gp_q <= 16'h0000;
            ptr_q <= 16'h0000;
            ia_q[0] <= `ADDR_RESET;
            ia_q[1] <= `ADDR_RESET;
            ia_q[2] <= `ADDR_RESET;
        end else if (load_done) begin
            if (is_gp_q) begin
                gp_q <= eng_rdata; // [RULE_10]
            end else if (step_q == 3'd0) begin
                cfg_q <= eng_rdata; // [RULE_07] [RULE_09]
            end else if (step_q == 3'd1) begin
                base_q <= eng_rdata;
            end else begin
                ia_q[2'(step_q - 3'd2)] <= eng_rdata; // [RULE_04]
            end
        end else if (wr_ok) begin
            unique case (reg_addr)
                `REG_CONFIG:   cfg_q <= reg_wdata;
                `REG_BASE:     base_q <= reg_wdata;
                `REG_POINTER:  ptr_q <= reg_wdata;
                `REG_GENERAL:  gp_q <= reg_wdata;
                `REG_ADDR_0_1: ia_q[0] <= reg_wdata;
                `REG_ADDR_2_3: ia_q[1] <= reg_wdata;
                `REG_ADDR_4_5: ia_q[2] <= reg_wdata;
                default: ;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Read port and setup outputs
    logic [15:0] base_eff;
    assign base_eff = (slot_q == `SLOT_DEFAULT) ? `BASE_FIXED : base_q; // [RULE_06]
    // Read data one cycle after the strobe; blocked reads return only control
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            if (reg_addr == `REG_CONTROL) begin
                reg_rdata <= blocked ? 16'h0003 | 16'({sel_q, 2'b00}) // [RULE_13]
                           : 16'({sel_q, reload_q, store_q});
            end else if (blocked) begin
                reg_rdata <= 16'h0000; // [RULE_14]
            end else begin
                unique case (reg_addr)
                    `REG_CONFIG:   reg_rdata <= cfg_q;
                    `REG_BASE:     reg_rdata <= base_eff;
                    `REG_POINTER:  reg_rdata <= ptr_q;
                    `REG_GENERAL:  reg_rdata <= gp_q;
                    `REG_ADDR_0_1: reg_rdata <= ia_q[0];
                    `REG_ADDR_2_3: reg_rdata <= ia_q[1];
                    `REG_ADDR_4_5: reg_rdata <= ia_q[2];
                    default:       reg_rdata <= 16'h0000;
                endcase
            end
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
    assign config_word = cfg_q;
    assign base_word = base_eff;
    assign station_addr = {ia_q[2], ia_q[1], ia_q[0]};
    ////////////////////////////////////////////////////////////////////////////
    // Checks
    // Straps settled and no ROM fitted: the select pin must never rise
    a_no_rom_absent: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_15]
        strap_ok_q && !pres_q |-> !rom_cs) else $error("ROM selected while absent");
    a_ctl_busy_read: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_13]
        reg_rd && reg_addr == `REG_CONTROL && blocked |=> reg_rdata[1:0] == 2'b11)
        else $error("Busy control read lacks both bits");
    a_blocked_write: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_14]
        blocked && reg_wr && reg_addr == `REG_CONFIG && !load_done |=> $stable(cfg_q))
        else $error("Write accepted while busy");
    a_one_start: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_17]
        eng_start |-> !eng_busy) else $error("Start while engine busy");
    a_slot_addr: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_03]
        eng_start && !is_store_q && !is_gp_q && step_q == 3'd1 |-> eng_cmd.addr == slot_base + 6'h01)
        else $error("Base word address wrong");
    a_addr_area: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_04]
        eng_start && !is_store_q && !is_gp_q && step_q == 3'd2 |-> eng_cmd.addr == `ROM_ADDR_AREA)
        else $error("Station address word wrong");
    a_gp_pointer: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_10]
        eng_start && is_gp_q && !eng_cmd.wren |-> eng_cmd.addr == ptr_q[5:0])
        else $error("General access ignores pointer");
    // Checked through the read port, so a stored base word cannot leak out
    a_fixed_base: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_06]
        reg_rd && reg_addr == `REG_BASE && !blocked && slot_q == `SLOT_DEFAULT
        |=> reg_rdata == `BASE_FIXED && base_word == `BASE_FIXED) else $error("Fixed base not used");
    a_cs_frame: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_16]
        eng_start |=> rom_cs) else $error("Select not raised for frame");
    c_boot_load: cover property (@(posedge clk_sys) disable iff (reset) load_done && step_q == 3'd4);
    c_store: cover property (@(posedge clk_sys) disable iff (reset) eng_start && eng_cmd.write);
    c_gp_read: cover property (@(posedge clk_sys) disable iff (reset) load_done && is_gp_q);
endmodule : serial_rom_config_loader

//--- src/rom_loader_params.svh
// Offsets, field positions, reset values and timing counts for the serial ROM configuration loader
`ifndef ROM_LOADER_PARAMS_SVH
`define ROM_LOADER_PARAMS_SVH
// Register offsets on the host port
`define REG_CONTROL      4'h0
`define REG_CONFIG       4'h1
`define REG_BASE         4'h2
`define REG_POINTER      4'h3
`define REG_GENERAL      4'h4
`define REG_ADDR_0_1     4'h5
`define REG_ADDR_2_3     4'h6
`define REG_ADDR_4_5     4'h7
// Control register bit positions
`define CTL_STORE        0
`define CTL_RELOAD       1
`define CTL_SELECT       2
// ROM map
`define ROM_ADDR_AREA    6'h20
`define SLOT_DEFAULT     3'h7
// Reset values
`define CONFIG_RESET     16'h0000
`define BASE_RESET       16'h0000
`define BASE_FIXED       16'h0000
`define ADDR_RESET       16'h0000
// Timing: serial clock no faster than 1 MHz, ready poll limit
`define SCLK_NS          1000
`define CLK_NS           25
`define SCLK_HALF_CYC    ((`SCLK_NS + 2 * `CLK_NS - 1) / (2 * `CLK_NS))
`define READY_POLL_MAX   20000
// Command opcodes (start bit, two opcode bits)
`define OP_READ          3'b110
`define OP_WRITE         3'b101
`define OP_WREN          3'b100
`define WREN_ADDR        6'h30
`endif

//--- src/rom_loader_pkg.sv
// Types shared by the serial ROM configuration loader
package rom_loader_pkg;
    // One serial command to the ROM
    typedef struct packed {
        logic       write;      // 1: write, 0: read
        logic       wren;       // Write-enable frame
        logic [5:0] addr;
        logic [15:0] data;
    } rom_cmd_s;
    // Host register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [15:0] wdata;
    } host_req_s;
endpackage : rom_loader_pkg

//--- src/sclk_divider.sv
// Enable pulse generator for the serial clock half period
module sclk_divider #(
    parameter int HALF_CYC = 20
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    // Control
    input  wire logic run,
    output logic      tick
);
    initial begin
        if (HALF_CYC < 1) $error("HALF_CYC must be at least one");
    end
    logic [15:0] cnt_q;
    // Free count while running; restart keeps phase aligned to frame start
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cnt_q <= 16'h0000;
        end else if (!run || cnt_q == 16'(HALF_CYC - 1)) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
    assign tick = run && cnt_q == 16'(HALF_CYC - 1);
endmodule : sclk_divider

//--- src/rom_serial_engine.sv
// Three-wire serial ROM frame engine: read, write-enable, write with ready polling
`include "rom_loader_params.svh"
module rom_serial_engine #(
    parameter int POLL_MAX = `READY_POLL_MAX
) (
    // Clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      reset,
    // Command
    input  wire logic                      start,
    input  wire rom_loader_pkg::rom_cmd_s  cmd,
    output logic                           busy,
    output logic                           done,
    output logic [15:0]                    rdata,
    // Half-period enable
    input  wire logic                      tick,
    output logic                           run,
    // ROM pins (data_in already synchronised)
    output logic                           rom_cs,
    output logic                           rom_sck,
    output logic                           rom_di,
    input  wire logic                      rom_do
);
    typedef enum logic [2:0] {S_IDLE = 3'b000, S_SHIFT = 3'b001, S_GAP = 3'b011,
                              S_POLL = 3'b010, S_END = 3'b110} eng_e;
    eng_e        st_q;
    logic [24:0] sh_q;
    logic [5:0]  bits_q;
    logic        phase_q;
    logic [15:0] rd_q;
    logic [31:0] poll_q;
    logic        wr_q;
    logic [4:0]  len;
    // Frame length: 3 opcode + 6 address, plus 16 data bits on read or write
    assign len = cmd.wren ? 5'd9 : 5'd25;
    assign busy = st_q != S_IDLE;
    assign run = busy;
    assign rdata = rd_q;
    // Serial frame sequencing, one bit per full serial clock period
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st_q <= S_IDLE;
            sh_q <= 25'h0;
            bits_q <= 6'h00;
            phase_q <= 1'b0;
            rd_q <= 16'h0000;
            poll_q <= 32'h0;
            wr_q <= 1'b0;
            rom_cs <= 1'b0;
            rom_sck <= 1'b0;
            rom_di <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (st_q)
                S_IDLE: begin
                    if (start) begin
                        sh_q <= cmd.wren ? {`OP_WREN, `WREN_ADDR, 16'h0000}
                              : {cmd.write ? `OP_WRITE : `OP_READ, cmd.addr, cmd.data};
                        bits_q <= {1'b0, len};
                        wr_q <= cmd.write && !cmd.wren;
                        phase_q <= 1'b0;
                        rom_cs <= 1'b1; // [RULE_16]
                        st_q <= S_SHIFT;
                    end
                end
                S_SHIFT: if (tick) begin
                    phase_q <= !phase_q;
                    if (!phase_q) begin
                        if (bits_q == 6'h00) begin
                            rom_cs <= 1'b0;
                            st_q <= S_GAP;
                        end else begin
                            rom_di <= sh_q[24];
                            sh_q <= {sh_q[23:0], 1'b0};
                            rom_sck <= 1'b0;
                        end
                    end else begin
                        rom_sck <= 1'b1;
                        bits_q <= bits_q - 6'h01;
                        if (bits_q <= 6'd16) begin
                            rd_q <= {rd_q[14:0], rom_do};
                        end
                    end
                end
                S_GAP: if (tick) begin
                    rom_sck <= 1'b0;
                    rom_di <= 1'b0;
                    // After a write, raise select and poll ready on data out
                    if (wr_q) begin
                        rom_cs <= 1'b1; // [RULE_16]
                        poll_q <= 32'h0;
                        st_q <= S_POLL;
                    end else begin
                        st_q <= S_END;
                    end
                end
                S_POLL: begin
                    poll_q <= poll_q + 32'h1;
                    if (rom_do || poll_q == 32'(POLL_MAX)) begin
                        rom_cs <= 1'b0;
                        st_q <= S_END;
                    end
                end
                S_END: begin
                    done <= 1'b1;
                    st_q <= S_IDLE;
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end
endmodule : rom_serial_engine

//--- sim/rom_model.sv
// Behavioural 64 x 16 three-wire serial ROM for the loader bench
module rom_model (
    // ROM pins
    input  wire logic rom_cs,
    input  wire logic rom_sck,
    input  wire logic rom_di,
    output logic      rom_do
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [64]; // Word array, whole words only
    logic [24:0] sh;
    logic [2:0]  op_q;
    logic [5:0]  a;
    logic        wen = 1'b0;
    int          n;
    initial rom_do = 1'b0;
    // Select starts a frame; ready shows at once, a released line never holds its value
    always @(posedge rom_cs) begin
        n = 0;
        op_q = 3'b000;
        rom_do = 1'b1; // Ready status while polled
    end
    always @(negedge rom_cs) rom_do = ~rom_do;
    // Shift in start, opcode, address and data on rising clock
    always @(posedge rom_sck) if (rom_cs) begin
        sh = {sh[23:0], rom_di};
        n++;
        if (n == 9) begin
            op_q = sh[8:6];
            a = sh[5:0];
            if (sh[8:6] == 3'b100) wen = (sh[5:4] == 2'b11); // Write-enable needed first
        end
        if (n == 25 && op_q == 3'b101 && wen) mem[a] = sh[15:0];
    end
    // Read data MSB first, changed on falling clock
    always @(negedge rom_sck) if (rom_cs && op_q == 3'b110 && n >= 9 && n < 25) rom_do = mem[a][24-n];
endmodule : rom_model

//--- sim/test_serial_rom_config_loader.sv
// Self-checking bench for the serial ROM configuration loader
`include "rom_loader_params.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; $display("MISMATCH %0t got %h want %h", $time, a, b); end end
module test_serial_rom_config_loader;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 0, reset = 1, reg_wr = 0, reg_rd = 0, rom_present_strap = 1, rd_seen = 0;
    logic [3:0]  reg_addr = 0;
    logic [15:0] reg_wdata = 0, reg_rdata, config_word, base_word, v, x, y;
    logic [2:0]  board_slot_straps = 3'h2;
    logic        rom_cs, rom_sck, rom_di, rom_do;
    logic [47:0] station_addr;
    logic [16:0] exp_q [$], e;
    logic [5:0]  p;
    int          bad_count = 0, tests_run = 0, cyc = 0, cs_count = 0, c;
    always #12.5 clk_sys = ~clk_sys;
    serial_rom_config_loader #(.POLL_MAX(50)) i_serial_rom_config_loader (.clk_sys(clk_sys), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .board_slot_straps(board_slot_straps), .rom_present_strap(rom_present_strap), .rom_cs(rom_cs),
        .rom_sck(rom_sck), .rom_di(rom_di), .rom_do(rom_do), .config_word(config_word), .base_word(base_word),
        .station_addr(station_addr));
    rom_model i_rom_model (.rom_cs(rom_cs), .rom_sck(rom_sck), .rom_di(rom_di), .rom_do(rom_do));
    // Oldest note is compared in the cycle after each read strobe
    always @(posedge clk_sys) rd_seen <= reg_rd;
    always @(negedge clk_sys) if (rd_seen) begin
        e = exp_q.pop_front();
        if (e[16]) `CHK(reg_rdata, e[15:0])
    end
    // Frame count and hang limit; a full run needs about 20k cycles
    always @(posedge rom_cs) cs_count++;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 90000) begin
            bad_count++;
            end_sim();
        end
    end
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 0;
    endtask : wr
    task rd(input logic [3:0] a, input logic [15:0] ex, input logic chk);
        exp_q.push_back({chk, ex});
        @(posedge clk_sys);
        reg_rd <= 1; reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 0;
        @(negedge clk_sys);
        v = reg_rdata;
    endtask : rd
    // Polling is the only legal wait; while busy other registers read zero
    task poll(input logic b);
        repeat (3) @(posedge clk_sys);
        if (b) rd(4'h1, 16'h0000, 1'b1);
        rd(4'h0, 16'h0000, 1'b0);
        if (b) `CHK(v[1:0], 2'b11)
        for (int i = 0; i < 500 && v[1:0] != 2'b00; i++) begin
            repeat (20) @(posedge clk_sys);
            rd(4'h0, 16'h0000, 1'b0);
        end
        `CHK(v[1:0], 2'b00)
    endtask : poll
    task do_reset(input logic [2:0] s, input logic pr);
        @(posedge clk_sys);
        reset <= 1; board_slot_straps <= s; rom_present_strap <= pr;
        repeat (16) @(posedge clk_sys);
        reset <= 0;
    endtask : do_reset
    task end_sim;
        $display("compared %0d, mismatched %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    // Main sequence: boot, store, general mode, reload, default slot, no ROM
    initial begin
        void'($urandom(32'ha6523cb1));
        for (int i = 0; i < 64; i++) i_rom_model.mem[i] = 16'($urandom);
        do_reset(3'h2, 1'b1);
        poll(1'b1);
        rd(4'h1, i_rom_model.mem[8], 1'b1);
        rd(4'h2, i_rom_model.mem[9], 1'b1);
        `CHK(station_addr, {i_rom_model.mem[34], i_rom_model.mem[33], i_rom_model.mem[32]})
        `CHK({config_word, base_word}, {i_rom_model.mem[8], i_rom_model.mem[9]})
        $display("boot load done");
        x = 16'($urandom); y = 16'($urandom);
        wr(4'h1, x); wr(4'h2, y); wr(4'h0, 16'h0001);
        wr(4'h1, ~x);
        poll(1'b1);
        `CHK({i_rom_model.mem[8], i_rom_model.mem[9]}, {x, y})
        rd(4'h1, x, 1'b1);
        $display("normal store done");
        p = 6'($urandom); x = 16'($urandom); y = 16'($urandom);
        wr(4'h3, {10'h000, p}); wr(4'h4, x); wr(4'h0, 16'h0005);
        poll(1'b1);
        `CHK(i_rom_model.mem[p], x)
        i_rom_model.mem[p ^ 6'h01] = y;
        wr(4'h3, {10'h000, p ^ 6'h01}); wr(4'h0, 16'h0006);
        poll(1'b1);
        `CHK(v[2:0], 3'b100)
        rd(4'h4, y, 1'b1);
        $display("general mode done");
        x = 16'($urandom); i_rom_model.mem[8] = x; i_rom_model.mem[33] = 16'($urandom);
        wr(4'h0, 16'h0003);
        poll(1'b1);
        rd(4'h1, x, 1'b1);
        `CHK(i_rom_model.mem[8], x)
        `CHK(station_addr[31:16], i_rom_model.mem[33])
        $display("normal reload done");
        do_reset(3'h7, 1'b1);
        poll(1'b1);
        wr(4'h2, x);
        rd(4'h2, `BASE_FIXED, 1'b1);
        `CHK(base_word, `BASE_FIXED)
        rd(4'h1, `CONFIG_RESET, 1'b1);
        `CHK(station_addr, {i_rom_model.mem[34], i_rom_model.mem[33], i_rom_model.mem[32]})
        $display("default slot done");
        do_reset(3'h2, 1'b0);
        c = cs_count;
        poll(1'b0);
        wr(4'h0, 16'h0002);
        poll(1'b0);
        `CHK(cs_count, c)
        rd(4'h5, `ADDR_RESET, 1'b1);
        $display("absent rom done");
        end_sim();
    end
endmodule : test_serial_rom_config_loader
